//--- rtl/nibble_pair_ram.sv
`timescale 1ns/1ps
`default_nettype none

module nibble_pair_ram #(
  parameter int AW = 8,
  parameter int DW = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // nibble write
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  // aligned pair read
  input wire logic [AW-2:0] rd_addr_i,
  output logic [2*DW-1:0] rd_data_o
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= {mem[{rd_addr_i, 1'b1}], mem[{rd_addr_i, 1'b0}]};
    end
  end

endmodule

`default_nettype wire

//--- rtl/skip_and_chain_load_sequencer.sv
// Contract
// RL1: accumulator and pointer immediate loads form chains
// RL2: only first executed chain member takes effect
// RL3: other class ends the chain, runs normally
// RL4: add with carry from pointer memory
// RL5: base-m add uses add, add-carry, add sequence
// RL6: add-carry carry skips following immediate add
// RL7: immediate add after memory op never skips
// RL8: carry shows base-m addition overflow
// RL9: subtract with borrow from pointer memory
// RL10: no borrow skips add, borrow runs unskippable
// RL11: carry shows base-m subtraction underflow
// RL12: met skip condition discards next instruction
// RL13: skipping long branch or call costs two
// RL14: skipping any other instruction costs one
// RL15: skipping table call costs one cycle
// RL16: one machine cycle per cpu clock
// RL17: eight nibble registers plus four expansion pairs
// RL18: A, XA and carry are accumulators
// RL19: byte memory operand must be even
// RL20: table call operand 20H-7FH, bit0 zero
// RL21: fixed area and pointer bit ranges
// RL22: branch span, call widths, bit number width
`timescale 1ns/1ps
`default_nettype none

module skip_and_chain_load_sequencer #(
  parameter int DMEM_AW = seq_pkg::DMEM_AW
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire seq_pkg::instr_t instr_i,
  output logic instr_ready_o,
  input wire logic [1:0] pc_block_i,
  // data memory loader
  input wire logic mem_wr_en_i,
  input wire logic [DMEM_AW-1:0] mem_wr_addr_i,
  input wire logic [3:0] mem_wr_data_i,
  // results
  output seq_pkg::retire_t retire_o,
  output seq_pkg::flow_t flow_o,
  output seq_pkg::view_t view_o,
  output logic [31:0] mcycle_count_o
);

  typedef enum logic [1:0] {st_fetch, st_mem, st_stall} state_t;

  state_t state_reg;
  state_t state_next;
  localparam int RF_DEPTH_W = 1;
  logic [RF_DEPTH_W-1:0] unused_w;
  logic [seq_pkg::RF_DEPTH-1:0][3:0] rf_reg;
  logic [seq_pkg::RF_DEPTH-1:0][3:0] rf_next;
  logic carry_reg;
  logic carry_next;
  logic skip_reg;
  logic skip_next;
  logic supp_reg;
  logic supp_next;
  seq_pkg::chain_t chain_reg;
  seq_pkg::chain_t chain_next;
  seq_pkg::instr_t pend_reg;
  seq_pkg::instr_t pend_next;
  seq_pkg::retire_t retire_reg;
  seq_pkg::retire_t retire_next;
  seq_pkg::flow_t flow_reg;
  seq_pkg::flow_t flow_next;
  logic [31:0] mcyc_reg;
  logic [31:0] mcyc_next;
  logic [DMEM_AW-2:0] rd_addr;
  logic [7:0] rd_pair;
  logic [3:0] mem_nib;
  logic [4:0] sum5;
  logic [4:0] diff5;

  assign unused_w = '0;

  function automatic seq_pkg::chain_t chain_of(input seq_pkg::op_t op);
    unique case (op)
      seq_pkg::op_mov_a_n4, seq_pkg::op_mov_xa_n8: chain_of = seq_pkg::chain_acc; // RL1
      seq_pkg::op_mov_hl_n8: chain_of = seq_pkg::chain_ptr; // RL1
      default: chain_of = seq_pkg::chain_none;
    endcase
  endfunction

  function automatic logic is_long3(input seq_pkg::op_t op);
    is_long3 = (op == seq_pkg::op_long_branch) || (op == seq_pkg::op_long_relative_branch) ||
               (op == seq_pkg::op_long_call) || (op == seq_pkg::op_long_relative_call);
  endfunction

  function automatic logic operand_ok(input seq_pkg::instr_t ins);
    logic [11:0] ba;
    ba = ins.addr[11:0];
    unique case (ins.op)
      seq_pkg::op_xa_from_mem: operand_ok = !ins.imm[0]; // RL19
      seq_pkg::op_one_byte_table_call: operand_ok = !ins.imm[0] && // RL20
        (ins.imm >= seq_pkg::TADDR_LO) && (ins.imm <= seq_pkg::TADDR_HI);
      seq_pkg::op_bit_fmem: operand_ok = (ins.addr[13:12] == 2'h0) && // RL21
        (((ba >= seq_pkg::FMEM_A_LO) && (ba <= seq_pkg::FMEM_A_HI)) ||
         ((ba >= seq_pkg::FMEM_B_LO) && (ba <= seq_pkg::MEM_TOP)));
      seq_pkg::op_bit_pmem: operand_ok = (ins.addr[13:12] == 2'h0) && // RL21
        (ba >= seq_pkg::PMEM_LO) && (ba <= seq_pkg::MEM_TOP);
      seq_pkg::op_block_call: operand_ok = (ins.addr[13:12] == 2'h0); // RL22
      seq_pkg::op_fixed_call: operand_ok = (ins.addr[13:11] == 3'h0); // RL22
      default: operand_ok = 1'b1;
    endcase
  endfunction

  // aligned pair read: byte operand address or the data pointer
  always_comb begin
    if ((state_reg == st_fetch) && (instr_i.op == seq_pkg::op_xa_from_mem)) begin
      rd_addr = instr_i.imm[DMEM_AW-1:1];
    end else begin
      rd_addr = {rf_reg[seq_pkg::IDX_H], rf_reg[seq_pkg::IDX_L][3:1]};
    end
  end

  nibble_pair_ram #(
    .AW(DMEM_AW),
    .DW(4)
  ) u_dmem (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(mem_wr_en_i),
    .wr_addr_i(mem_wr_addr_i),
    .wr_data_i(mem_wr_data_i),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_pair)
  );

  assign mem_nib = rf_reg[seq_pkg::IDX_L][0] ? rd_pair[7:4] : rd_pair[3:0];
  assign sum5 = {1'b0, rf_reg[seq_pkg::IDX_A]} + {1'b0, mem_nib} + {4'h0, carry_reg}; // RL4
  assign diff5 = {1'b0, rf_reg[seq_pkg::IDX_A]} - {1'b0, mem_nib} - {4'h0, carry_reg}; // RL9

  always_comb begin
    logic [4:0] add5;
    logic [3:0] hi_i;
    logic [3:0] lo_i;
    add5 = '0;
    hi_i = {instr_i.pair, 1'b0};
    lo_i = {instr_i.pair, 1'b1};
    state_next = state_reg;
    rf_next = rf_reg;
    carry_next = carry_reg;
    skip_next = skip_reg;
    supp_next = supp_reg;
    chain_next = chain_reg;
    pend_next = pend_reg;
    retire_next = '0;
    flow_next = '0;
    mcyc_next = mcyc_reg + 32'h00000001; // RL16
    unique case (state_reg)
      st_fetch: begin
        if (instr_valid_i) begin
          pend_next = instr_i;
          if (skip_reg) begin
            skip_next = 1'b0; // RL12
            supp_next = 1'b0;
            chain_next = seq_pkg::chain_none;
            if (is_long3(instr_i.op)) begin
              state_next = st_stall; // RL13
            end else begin
              retire_next = {1'b1, seq_pkg::ret_skipped, seq_pkg::SKIP_CYC_SHORT}; // RL14 RL15
            end
          end else if ((chain_of(instr_i.op) != seq_pkg::chain_none) &&
                       (chain_of(instr_i.op) == chain_reg)) begin
            supp_next = 1'b0;
            retire_next = {1'b1, seq_pkg::ret_chain_nop, seq_pkg::EXEC_CYC}; // RL2
          end else if (!operand_ok(instr_i)) begin
            supp_next = 1'b0;
            chain_next = seq_pkg::chain_none;
            retire_next = {1'b1, seq_pkg::ret_bad_operand, seq_pkg::EXEC_CYC};
          end else begin
            chain_next = chain_of(instr_i.op); // RL3
            supp_next = 1'b0;
            retire_next = {1'b1, seq_pkg::ret_exec, seq_pkg::EXEC_CYC};
            unique case (instr_i.op)
              seq_pkg::op_mov_a_n4: begin
                rf_next[seq_pkg::IDX_A] = instr_i.imm[3:0]; // RL18
              end
              seq_pkg::op_mov_xa_n8: begin
                rf_next[seq_pkg::IDX_X] = instr_i.imm[7:4]; // RL18
                rf_next[seq_pkg::IDX_A] = instr_i.imm[3:0];
              end
              seq_pkg::op_mov_hl_n8: begin
                rf_next[seq_pkg::IDX_H] = instr_i.imm[7:4];
                rf_next[seq_pkg::IDX_L] = instr_i.imm[3:0];
              end
              seq_pkg::op_skipping_immediate_add: begin
                add5 = {1'b0, rf_reg[seq_pkg::IDX_A]} + {1'b0, instr_i.imm[3:0]}; // RL5
                rf_next[seq_pkg::IDX_A] = add5[3:0];
                skip_next = add5[4] && !supp_reg; // RL7 RL12
              end
              seq_pkg::op_add_with_carry, seq_pkg::op_subtract_with_borrow,
              seq_pkg::op_xa_from_mem: begin
                retire_next = '0;
                state_next = st_mem;
              end
              seq_pkg::op_move_xa_from_pair: begin
                rf_next[seq_pkg::IDX_X] = rf_reg[hi_i]; // RL17
                rf_next[seq_pkg::IDX_A] = rf_reg[lo_i];
              end
              seq_pkg::op_move_pair_from_xa: begin
                rf_next[hi_i] = rf_reg[seq_pkg::IDX_X]; // RL17
                rf_next[lo_i] = rf_reg[seq_pkg::IDX_A];
              end
              seq_pkg::op_long_branch, seq_pkg::op_long_relative_branch,
              seq_pkg::op_long_call, seq_pkg::op_long_relative_call: begin
                flow_next = {1'b1, 1'b0, instr_i.addr}; // RL22
              end
              seq_pkg::op_block_call: begin
                flow_next = {1'b1, 1'b0, pc_block_i, instr_i.addr[seq_pkg::CADDR_W-1:0]}; // RL22
              end
              seq_pkg::op_fixed_call: begin
                flow_next = {1'b1, 1'b0, 3'h0, instr_i.addr[seq_pkg::FADDR_W-1:0]}; // RL22
              end
              seq_pkg::op_one_byte_table_call: begin
                flow_next = {1'b1, 1'b1, 6'h00, instr_i.imm}; // RL20
              end
              default: begin
              end
            endcase
          end
        end
      end
      st_mem: begin
        state_next = st_fetch;
        retire_next = {1'b1, seq_pkg::ret_exec, seq_pkg::MEM_CYC};
        unique case (pend_reg.op)
          seq_pkg::op_add_with_carry: begin
            rf_next[seq_pkg::IDX_A] = sum5[3:0]; // RL4
            carry_next = sum5[4]; // RL8
            skip_next = sum5[4]; // RL6
            supp_next = 1'b1; // RL7
          end
          seq_pkg::op_subtract_with_borrow: begin
            rf_next[seq_pkg::IDX_A] = diff5[3:0]; // RL9
            carry_next = diff5[4]; // RL11
            skip_next = !diff5[4]; // RL10
            supp_next = 1'b1; // RL10
          end
          default: begin
            rf_next[seq_pkg::IDX_A] = rd_pair[3:0]; // RL19
            rf_next[seq_pkg::IDX_X] = rd_pair[7:4];
          end
        endcase
      end
      st_stall: begin
        state_next = st_fetch;
        retire_next = {1'b1, seq_pkg::ret_skipped, seq_pkg::SKIP_CYC_LONG}; // RL13
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= st_fetch;
      rf_reg <= {seq_pkg::RF_DEPTH{seq_pkg::RESET_NIB}};
      carry_reg <= 1'b0;
      skip_reg <= 1'b0;
      supp_reg <= 1'b0;
      chain_reg <= seq_pkg::chain_none;
      pend_reg <= '0;
      retire_reg <= '0;
      flow_reg <= '0;
      mcyc_reg <= '0;
    end else begin
      state_reg <= state_next;
      rf_reg <= rf_next;
      carry_reg <= carry_next;
      skip_reg <= skip_next;
      supp_reg <= supp_next;
      chain_reg <= chain_next;
      pend_reg <= pend_next;
      retire_reg <= retire_next;
      flow_reg <= flow_next;
      mcyc_reg <= mcyc_next;
    end
  end

  assign instr_ready_o = (state_reg == st_fetch);
  assign retire_o = retire_reg;
  assign flow_o = flow_reg;
  assign mcycle_count_o = mcyc_reg;
  assign view_o = {rf_reg[seq_pkg::IDX_X], rf_reg[seq_pkg::IDX_A], rf_reg[seq_pkg::IDX_H],
                   rf_reg[seq_pkg::IDX_L], carry_reg, skip_reg, chain_reg};

endmodule

`default_nettype wire

//--- shared/seq_pkg.sv
package seq_pkg;

  // register file slots, pair p is slots 2p (high) and 2p+1 (low)
  localparam logic [3:0] IDX_X = 4'h0;
  localparam logic [3:0] IDX_A = 4'h1;
  localparam logic [3:0] IDX_H = 4'h6;
  localparam logic [3:0] IDX_L = 4'h7;
  localparam int RF_DEPTH = 16;
  localparam logic [3:0] RESET_NIB = 4'h0;

  // operand ranges
  localparam logic [7:0] TADDR_LO = 8'h20;
  localparam logic [7:0] TADDR_HI = 8'h7F;
  localparam logic [11:0] FMEM_A_LO = 12'hFB0;
  localparam logic [11:0] FMEM_A_HI = 12'hFBF;
  localparam logic [11:0] FMEM_B_LO = 12'hFF0;
  localparam logic [11:0] PMEM_LO = 12'hFC0;
  localparam logic [11:0] MEM_TOP = 12'hFFF;
  localparam int PC_W = 14;
  localparam int CADDR_W = 12;
  localparam int FADDR_W = 11;
  localparam int BIT_W = 2;
  localparam int DMEM_AW = 8;

  // machine cycle costs, one machine cycle per clock
  localparam logic [1:0] EXEC_CYC = 2'h1;
  localparam logic [1:0] MEM_CYC = 2'h2;
  localparam logic [1:0] SKIP_CYC_SHORT = 2'h1;
  localparam logic [1:0] SKIP_CYC_LONG = 2'h2;

  typedef enum logic [4:0] {
    op_nop,
    op_mov_a_n4,
    op_mov_xa_n8,
    op_mov_hl_n8,
    op_skipping_immediate_add,
    op_add_with_carry,
    op_subtract_with_borrow,
    op_move_xa_from_pair,
    op_move_pair_from_xa,
    op_xa_from_mem,
    op_long_branch,
    op_long_relative_branch,
    op_long_call,
    op_long_relative_call,
    op_one_byte_table_call,
    op_block_call,
    op_fixed_call,
    op_bit_fmem,
    op_bit_pmem,
    op_other
  } op_t;

  typedef enum logic [1:0] {chain_none, chain_acc, chain_ptr} chain_t;

  typedef enum logic [1:0] {ret_exec, ret_chain_nop, ret_skipped, ret_bad_operand} ret_t;

  typedef struct packed {
    op_t op;
    logic [7:0] imm;
    logic [2:0] pair;
    logic [PC_W-1:0] addr;
    logic [BIT_W-1:0] bitno;
  } instr_t;

  typedef struct packed {
    logic valid;
    ret_t kind;
    logic [1:0] cycles;
  } retire_t;

  typedef struct packed {
    logic req;
    logic table_call;
    logic [PC_W-1:0] target;
  } flow_t;

  typedef struct packed {
    logic [3:0] x;
    logic [3:0] a;
    logic [3:0] h;
    logic [3:0] l;
    logic carry;
    logic skip_pending;
    chain_t chain;
  } view_t;

endpackage

//--- tb/skip_and_chain_load_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module skip_chain_checker #(
  parameter int DMEM_AW = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire seq_pkg::instr_t instr_i,
  input wire logic instr_ready_o,
  input wire logic [1:0] pc_block_i,
  // data memory loader
  input wire logic mem_wr_en_i,
  input wire logic [DMEM_AW-1:0] mem_wr_addr_i,
  input wire logic [3:0] mem_wr_data_i,
  // results
  input wire seq_pkg::retire_t retire_o,
  input wire seq_pkg::flow_t flow_o,
  input wire seq_pkg::view_t view_o,
  input wire logic [31:0] mcycle_count_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // instruction accepted, with or without a pending skip
  sequence take(seq_pkg::op_t o, logic s);
    instr_valid_i && instr_ready_o && instr_i.op == o && view_o.skip_pending == s;
  endsequence
  sequence ret(seq_pkg::ret_t k, logic [1:0] c);
    retire_o.valid && retire_o.kind == k && retire_o.cycles == c;
  endsequence
  chain_acc_nop_a: assert property (
    take(seq_pkg::op_mov_xa_n8, 1'b0) ##0 view_o.chain == seq_pkg::chain_acc |=>
    retire_o.kind == seq_pkg::ret_chain_nop && $stable(view_o.a) && $stable(view_o.x))
    else $error("chained accumulator load took effect");
  chain_ptr_nop_a: assert property (
    take(seq_pkg::op_mov_hl_n8, 1'b0) ##0 view_o.chain == seq_pkg::chain_ptr |=>
    retire_o.kind == seq_pkg::ret_chain_nop && $stable(view_o.l))
    else $error("chained pointer load took effect");
  adc_timing_a: assert property (
    take(seq_pkg::op_add_with_carry, 1'b0) |=> !instr_ready_o ##1 ret(seq_pkg::ret_exec, 2'h2))
    else $error("memory add timing wrong");
  adc_skip_a: assert property (
    take(seq_pkg::op_add_with_carry, 1'b0) |-> ##2 view_o.skip_pending == view_o.carry)
    else $error("memory add skip not tied to carry");
  sbc_skip_a: assert property (
    take(seq_pkg::op_subtract_with_borrow, 1'b0) |-> ##2 view_o.skip_pending == !view_o.carry)
    else $error("subtract skip not tied to borrow");
  long_skip_a: assert property (
    take(seq_pkg::op_long_branch, 1'b1) |=> !instr_ready_o ##1 ret(seq_pkg::ret_skipped, 2'h2))
    else $error("long skip cost wrong");
  short_skip_a: assert property (
    take(seq_pkg::op_one_byte_table_call, 1'b1) |=> ret(seq_pkg::ret_skipped, 2'h1) && !flow_o.req)
    else $error("table call skip wrong");
  branch_flow_a: assert property (
    take(seq_pkg::op_long_branch, 1'b0) |=> flow_o.req && flow_o.target == $past(instr_i.addr))
    else $error("branch target wrong");
  table_bad_a: assert property (
    take(seq_pkg::op_one_byte_table_call, 1'b0) ##0 instr_i.imm[0] |=>
    retire_o.kind == seq_pkg::ret_bad_operand && !flow_o.req)
    else $error("odd table operand accepted");
endmodule
bind skip_and_chain_load_sequencer skip_chain_checker #(.DMEM_AW(DMEM_AW)) chk_i (
  .ref_clk_i, .rst_n_i, .instr_valid_i, .instr_i, .instr_ready_o, .pc_block_i, .mem_wr_en_i,
  .mem_wr_addr_i, .mem_wr_data_i, .retire_o, .flow_o, .view_o, .mcycle_count_o
);
`default_nettype wire

//--- tb/tb_skip_and_chain_load_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_skip_and_chain_load_sequencer;
  typedef struct packed {
    seq_pkg::op_t op;
    logic [7:0] imm;
    seq_pkg::ret_t kind;
    logic [1:0] cyc;
    logic [3:0] a;
    logic c;
  } row_t;
  localparam seq_pkg::op_t mva = seq_pkg::op_mov_a_n4;
  localparam seq_pkg::op_t mvx = seq_pkg::op_mov_xa_n8;
  localparam seq_pkg::op_t mvh = seq_pkg::op_mov_hl_n8;
  localparam seq_pkg::op_t ads = seq_pkg::op_skipping_immediate_add;
  localparam seq_pkg::op_t adc = seq_pkg::op_add_with_carry;
  localparam seq_pkg::op_t sbc = seq_pkg::op_subtract_with_borrow;
  localparam seq_pkg::op_t lbr = seq_pkg::op_long_branch;
  localparam seq_pkg::op_t tbc = seq_pkg::op_one_byte_table_call;
  localparam seq_pkg::ret_t ex = seq_pkg::ret_exec;
  localparam seq_pkg::ret_t np = seq_pkg::ret_chain_nop;
  localparam seq_pkg::ret_t sk = seq_pkg::ret_skipped;
  localparam seq_pkg::ret_t bd = seq_pkg::ret_bad_operand;
  logic ref_clk_i, rst_n_i, instr_valid_i, instr_ready_o, mem_wr_en_i;
  logic [1:0] pc_block_i;
  logic [7:0] mem_wr_addr_i;
  logic [3:0] mem_wr_data_i;
  logic [31:0] mcycle_count_o, mc0;
  seq_pkg::instr_t instr_i;
  seq_pkg::retire_t retire_o;
  seq_pkg::flow_t flow_o, fl_seen;
  seq_pkg::view_t view_o;
  int bad_count, n_checks;
  // program: chains, decimal add and subtract, skip costs, operand checks
  row_t rows [32] = '{
    '{mvh, 8'h10, ex, 2'h0, 4'h0, 1'h0}, '{mva, 8'h05, ex, 2'h0, 4'h5, 1'h0},
    '{mva, 8'h09, np, 2'h0, 4'h5, 1'h0}, '{mvx, 8'h3C, np, 2'h0, 4'h5, 1'h0},
    '{mvh, 8'h10, ex, 2'h0, 4'h5, 1'h0}, '{mvh, 8'h20, np, 2'h0, 4'h5, 1'h0},
    '{ads, 8'h06, ex, 2'h1, 4'hB, 1'h0}, '{adc, 8'h00, ex, 2'h2, 4'h2, 1'h1},
    '{ads, 8'h0A, sk, 2'h1, 4'h2, 1'h1}, '{mva, 8'h01, ex, 2'h0, 4'h1, 1'h1},
    '{ads, 8'h06, ex, 2'h1, 4'h7, 1'h1}, '{adc, 8'h00, ex, 2'h2, 4'hF, 1'h0},
    '{ads, 8'h0A, ex, 2'h1, 4'h9, 1'h0}, '{mva, 8'h03, ex, 2'h0, 4'h3, 1'h0},
    '{sbc, 8'h00, ex, 2'h2, 4'hC, 1'h1}, '{ads, 8'h0A, ex, 2'h1, 4'h6, 1'h1},
    '{mva, 8'h08, ex, 2'h0, 4'h8, 1'h1}, '{sbc, 8'h00, ex, 2'h2, 4'h0, 1'h0},
    '{ads, 8'h0A, sk, 2'h1, 4'h0, 1'h0}, '{mva, 8'h0F, ex, 2'h0, 4'hF, 1'h0},
    '{ads, 8'h01, ex, 2'h1, 4'h0, 1'h0}, '{lbr, 8'h40, sk, 2'h2, 4'h0, 1'h0},
    '{mva, 8'h0F, ex, 2'h0, 4'hF, 1'h0}, '{ads, 8'h01, ex, 2'h1, 4'h0, 1'h0},
    '{tbc, 8'h20, sk, 2'h1, 4'h0, 1'h0}, '{mva, 8'h0F, ex, 2'h0, 4'hF, 1'h0},
    '{ads, 8'h01, ex, 2'h1, 4'h0, 1'h0},
    '{seq_pkg::op_long_relative_call, 8'h40, sk, 2'h2, 4'h0, 1'h0},
    '{tbc, 8'h21, bd, 2'h0, 4'h0, 1'h0}, '{tbc, 8'h22, ex, 2'h0, 4'h0, 1'h0},
    '{lbr, 8'h34, ex, 2'h0, 4'h0, 1'h0},
    '{seq_pkg::op_xa_from_mem, 8'h11, bd, 2'h0, 4'h0, 1'h0}
  };

  skip_and_chain_load_sequencer skip_and_chain_load_sequencer_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o), .pc_block_i(pc_block_i),
    .mem_wr_en_i(mem_wr_en_i), .mem_wr_addr_i(mem_wr_addr_i), .mem_wr_data_i(mem_wr_data_i),
    .retire_o(retire_o), .flow_o(flow_o), .view_o(view_o), .mcycle_count_o(mcycle_count_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (flow_o.req === 1'b1) fl_seen <= flow_o;
  end

  task conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // offer one instruction, wait for its retirement, compare
  task run(input row_t r);
    int k;
    instr_valid_i = 1'b1;
    instr_i = '{r.op, r.imm, 3'h0, {6'h00, r.imm}, 2'h0};
    k = 0;
    while (instr_ready_o !== 1'b1 && k < 20) begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    @(posedge ref_clk_i);
    #1;
    while (retire_o.valid !== 1'b1 && k < 20) begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
    if (k >= 20) begin
      bad_count++;
      conclude();
    end
    chk("kind", r.kind, retire_o.kind);
    if (r.cyc != 2'h0) chk("cycles", r.cyc, retire_o.cycles);
    chk("acc", r.a, view_o.a);
    chk("carry", r.c, view_o.carry);
  endtask

  initial begin
    rst_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = '0;
    pc_block_i = 2'h2;
    mem_wr_en_i = 1'b0;
    mem_wr_addr_i = 8'h10;
    mem_wr_data_i = 4'h7;
    repeat (3) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    mem_wr_en_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    mem_wr_en_i = 1'b0;
    foreach (rows[i]) run(rows[i]);
    instr_valid_i = 1'b0;
    chk("pointer", 8'h10, {view_o.h, view_o.l});
    // block call target takes the program block bits
    run('{seq_pkg::op_block_call, 8'h45, ex, 2'h0, 4'h0, 1'h0});
    instr_valid_i = 1'b0;
    chk("target", 14'h2045, flow_o.target);
    mc0 = mcycle_count_o;
    repeat (10) @(posedge ref_clk_i);
    #1;
    chk("mcycles", 32'hA, mcycle_count_o - mc0);
    chk("seen", 14'h2045, fl_seen.target);
    rst_n_i = 1'b0;
    #1;
    chk("view", 20'h00000, view_o);
    chk("ready", 1'b1, instr_ready_o);
    chk("retire", 5'h00, retire_o);
    conclude();
  end
endmodule
`default_nettype wire
